// ==== rtl/bram_aspect_core.sv ====
// Purpose: Dual-port 18-kilobit memory with independent port aspect ratios and write modes.
// Assumes: Port clocks are pins sampled by the system clock, well below half its rate.
// Notes: Controls, address and data must be stable from the port clock edge until it is seen.
//
`timescale 1ns/10ps
module bram_aspect_core import bram_aspect_pkg::*; #(
    parameter int WIDTH_A = 36,
    parameter int WIDTH_B = 9,
    parameter wmode_t MODE_A = MODE_NEW_DATA,
    parameter wmode_t MODE_B = MODE_NEW_DATA,
    parameter bit DUAL_PORT = 1'b1,
    parameter logic [3:0] INVERT_A = 4'h0,
    parameter logic [3:0] INVERT_B = 4'h0,
    parameter logic [WORD_BITS-1:0] SET_DATA_A = 32'h00000000,
    parameter logic [WORD_BITS-1:0] SET_DATA_B = 32'h00000000,
    parameter logic [PAR_BITS-1:0] SET_PAR_A = 4'h0,
    parameter logic [PAR_BITS-1:0] SET_PAR_B = 4'h0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic port_clk_a,
    input wire logic port_enable_a,
    input wire logic write_enable_a,
    input wire logic output_set_reset_a,
    input wire logic [ADDR_BITS-1:0] address_a,
    input wire logic [WORD_BITS-1:0] write_data_bus_a,
    input wire logic [PAR_BITS-1:0] parity_write_bus_a,
    input wire logic port_clk_b,
    input wire logic port_enable_b,
    input wire logic write_enable_b,
    input wire logic output_set_reset_b,
    input wire logic [ADDR_BITS-1:0] address_b,
    input wire logic [WORD_BITS-1:0] write_data_bus_b,
    input wire logic [PAR_BITS-1:0] parity_write_bus_b,
    output logic [WORD_BITS-1:0] read_data_bus_a,
    output logic [PAR_BITS-1:0] parity_read_bus_a,
    output logic [MULT_BITS-1:0] mult_operand_a,
    output logic [WORD_BITS-1:0] read_data_bus_b,
    output logic [PAR_BITS-1:0] parity_read_bus_b,
    output logic [MULT_BITS-1:0] mult_operand_b
);

    ////////////////////////////////////////////////////////////////////////////////
    // Shared storage and per-port gathering.

    // One word holds 32 data bits; the parity array runs beside it.
    logic [WORD_BITS-1:0] mem_data [WORDS];
    logic [PAR_BITS-1:0] mem_par [WORDS];

    wire [1:0] clk_in;
    wire [1:0] en_in;
    wire [1:0] we_in;
    wire [1:0] ssr_in;
    wire [1:0][ADDR_BITS-1:0] addr_in;
    wire [1:0][WORD_BITS-1:0] wdata_in;
    wire [1:0][PAR_BITS-1:0] wpar_in;

    wire [1:0] fire;
    wire [1:0] wr;
    wire [1:0][IDX_BITS-1:0] idx;
    wire [1:0][WORD_BITS-1:0] dmask;
    wire [1:0][WORD_BITS-1:0] dpos;
    wire [1:0][PAR_BITS-1:0] pmask;
    wire [1:0][PAR_BITS-1:0] ppos;

    assign clk_in = {port_clk_b, port_clk_a};
    assign en_in = {port_enable_b, port_enable_a};
    assign we_in = {write_enable_b, write_enable_a};
    assign ssr_in = {output_set_reset_b, output_set_reset_a};
    assign addr_in = {address_b, address_a};
    assign wdata_in = {write_data_bus_b, write_data_bus_a};
    assign wpar_in = {parity_write_bus_b, parity_write_bus_a};

    ////////////////////////////////////////////////////////////////////////////////
    // Per-port edge detection, mapping and read output.

    for (genvar p = 0; p < 2; p++) begin : gen_port
        localparam int W = (p == 0) ? WIDTH_A : WIDTH_B;
        localparam wmode_t MODE = (p == 0) ? MODE_A : MODE_B;
        localparam logic [3:0] INV = (p == 0) ? INVERT_A : INVERT_B;
        localparam logic [WORD_BITS-1:0] SET_DATA = (p == 0) ? SET_DATA_A : SET_DATA_B;
        localparam logic [PAR_BITS-1:0] SET_PAR = (p == 0) ? SET_PAR_A : SET_PAR_B;
        // Port B never fires in single-port use; its multiplier operand still follows its write data.
        localparam bit PRESENT = (p == 0) ? 1'b1 : DUAL_PORT;

        logic [SYNC_STAGES-1:0] sync_q;
        logic [WORD_BITS-1:0] dout_q;
        logic [PAR_BITS-1:0] pout_q;
        logic [MULT_BITS-1:0] operand_q;
        wire edge_seen;
        wire en_act;
        wire we_act;
        wire ssr_act;
        wire [WORD_BITS-1:0] rdata;
        wire [PAR_BITS-1:0] rpar;
        wire [WORD_BITS-1:0] wdata_cut;
        wire [PAR_BITS-1:0] wpar_cut;

        // The port clock is a pin, so it is sampled three deep and an edge counts
        // only while the second stage holds the new level and the third still the old one.
        always_ff @(posedge clock) begin
            if (rst) begin
                sync_q <= '0;
            end else begin
                sync_q <= {sync_q[SYNC_STAGES-2:0], clk_in[p]};
            end
        end

        assign edge_seen = (sync_q[1] != sync_q[2]) && ((sync_q[1] ^ INV[INV_CLK]) == 1'b1);
        assign en_act = en_in[p] ^ INV[INV_EN];
        assign we_act = we_in[p] ^ INV[INV_WE];
        assign ssr_act = ssr_in[p] ^ INV[INV_SSR];
        assign fire[p] = PRESENT && edge_seen && en_act;
        assign wr[p] = fire[p] && we_act;

        bram_lane_map #(
            .WIDTH(W)
        ) u_map (
            .addr(addr_in[p]),
            .wdata(wdata_in[p]),
            .wpar(wpar_in[p]),
            .word_rd(mem_data[idx[p]]),
            .par_rd(mem_par[idx[p]]),
            .idx(idx[p]),
            .dmask(dmask[p]),
            .dpos(dpos[p]),
            .pmask(pmask[p]),
            .ppos(ppos[p]),
            .rdata(rdata),
            .rpar(rpar),
            .wdata_cut(wdata_cut),
            .wpar_cut(wpar_cut)
        );

        // Set/reset only loads the output latch; a write in the same edge still lands.
        always_ff @(posedge clock) begin
            if (rst) begin
                dout_q <= '0;
                pout_q <= '0;
            end else if (fire[p]) begin
                if (ssr_act) begin
                    dout_q <= SET_DATA;
                    pout_q <= SET_PAR;
                end else if (!we_act) begin
                    dout_q <= rdata;
                    pout_q <= rpar;
                end else begin
                    case (MODE)
                        MODE_NEW_DATA: begin
                            dout_q <= wdata_cut;
                            pout_q <= wpar_cut;
                        end
                        MODE_OLD_DATA: begin
                            dout_q <= rdata;
                            pout_q <= rpar;
                        end
                        MODE_HOLD: begin
                            dout_q <= dout_q;
                            pout_q <= pout_q;
                        end
                        default: begin
                            dout_q <= dout_q;
                            pout_q <= pout_q;
                        end
                    endcase
                end
            end
        end

        // The multiplier sees the top 16 write data bits with no port clock gating.
        always_ff @(posedge clock) begin
            if (rst) begin
                operand_q <= '0;
            end else begin
                operand_q <= wdata_in[p][WORD_BITS-1 -: MULT_BITS];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write path.

    wire same_word;
    wire [WORD_BITS-1:0] merged0;
    wire [WORD_BITS-1:0] base1;
    wire [WORD_BITS-1:0] merged1;
    wire [PAR_BITS-1:0] pmerged0;
    wire [PAR_BITS-1:0] pbase1;
    wire [PAR_BITS-1:0] pmerged1;

    // Two ports may write different slices of one storage word in the same
    // cycle; port B merges on top of port A's result so neither slice is lost.
    // Overlapping bits end with port B's value, which is only a tie-break.
    assign same_word = idx[0] == idx[1];
    assign merged0 = (mem_data[idx[0]] & ~dmask[0]) | dpos[0];
    assign base1 = (wr[0] && same_word) ? merged0 : mem_data[idx[1]];
    assign merged1 = (base1 & ~dmask[1]) | dpos[1];
    assign pmerged0 = (mem_par[idx[0]] & ~pmask[0]) | ppos[0];
    assign pbase1 = (wr[0] && same_word) ? pmerged0 : mem_par[idx[1]];
    assign pmerged1 = (pbase1 & ~pmask[1]) | ppos[1];

    // Contents are not cleared by reset, like the array they model.
    always_ff @(posedge clock) begin
        if (wr[0]) begin
            mem_data[idx[0]] <= merged0;
            mem_par[idx[0]] <= pmerged0;
        end
        if (wr[1]) begin
            mem_data[idx[1]] <= merged1;
            mem_par[idx[1]] <= pmerged1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flip-flop.

    assign read_data_bus_a = gen_port[0].dout_q;
    assign parity_read_bus_a = gen_port[0].pout_q;
    assign mult_operand_a = gen_port[0].operand_q;
    assign read_data_bus_b = gen_port[1].dout_q;
    assign parity_read_bus_b = gen_port[1].pout_q;
    assign mult_operand_b = gen_port[1].operand_q;

endmodule : bram_aspect_core

// ==== rtl/bram_aspect_pkg.sv ====
// Purpose: Shared constants, write modes and width decoding for the aspect-ratio block memory.
// Assumes: Port widths are one of 1, 2, 4, 9, 18 or 36 total bits.
// Notes: Storage is 512 words of 32 data bits plus 4 parity bits, one parity bit per byte.
package bram_aspect_pkg;

    localparam int ADDR_BITS = 14;
    localparam int WORD_BITS = 32;
    localparam int PAR_BITS = 4;
    localparam int WORDS = 512;
    localparam int IDX_BITS = 9;
    localparam int OFF_BITS = 5;
    localparam int POFF_BITS = 2;
    localparam int MULT_BITS = 16;
    localparam int SYNC_STAGES = 3;
    localparam int CAPACITY_WITH_PARITY = 18432;
    localparam int CAPACITY_DATA_ONLY = 16384;

    // Inversion mask bit positions for the per-port control polarity.
    localparam int INV_CLK = 0;
    localparam int INV_EN = 1;
    localparam int INV_WE = 2;
    localparam int INV_SSR = 3;

    typedef enum logic [1:0] {
        MODE_NEW_DATA = 2'b00,
        MODE_OLD_DATA = 2'b01,
        MODE_HOLD = 2'b10
    } wmode_t;

    // Log2 of the data lane width for a total path width.
    function automatic int lg_data(input int w);
        case (w)
            1: lg_data = 0;
            2: lg_data = 1;
            4: lg_data = 2;
            9: lg_data = 3;
            18: lg_data = 4;
            default: lg_data = 5;
        endcase
    endfunction : lg_data

    // Parity lanes for a total path width; narrow widths carry none.
    function automatic int par_of(input int w);
        case (w)
            9: par_of = 1;
            18: par_of = 2;
            36: par_of = 4;
            default: par_of = 0;
        endcase
    endfunction : par_of

endpackage : bram_aspect_pkg

// ==== rtl/bram_lane_map.sv ====
// Purpose: Maps one port's address and width onto the shared 36-bit storage words.
// Assumes: WIDTH is a legal total path width.
// Notes: Purely combinational; the parity slot index equals the byte index of its data.
`timescale 1ns/10ps
module bram_lane_map import bram_aspect_pkg::*; #(
    parameter int WIDTH = 36
) (
    input wire logic [ADDR_BITS-1:0] addr,
    input wire logic [WORD_BITS-1:0] wdata,
    input wire logic [PAR_BITS-1:0] wpar,
    input wire logic [WORD_BITS-1:0] word_rd,
    input wire logic [PAR_BITS-1:0] par_rd,
    output logic [IDX_BITS-1:0] idx,
    output logic [WORD_BITS-1:0] dmask,
    output logic [WORD_BITS-1:0] dpos,
    output logic [PAR_BITS-1:0] pmask,
    output logic [PAR_BITS-1:0] ppos,
    output logic [WORD_BITS-1:0] rdata,
    output logic [PAR_BITS-1:0] rpar,
    output logic [WORD_BITS-1:0] wdata_cut,
    output logic [PAR_BITS-1:0] wpar_cut
);

    localparam int LGD = lg_data(WIDTH);
    localparam int DW = 1 << LGD;
    localparam int PW = par_of(WIDTH);
    localparam int LGP = (LGD >= 3) ? LGD - 3 : 0;
    localparam int SUB = OFF_BITS - LGD;
    localparam logic [WORD_BITS-1:0] LOW_D = {WORD_BITS{1'b1}} >> (WORD_BITS - DW);
    localparam logic [PAR_BITS-1:0] LOW_P = (PW == 0) ? 4'h0 : (4'hF >> (PAR_BITS - PW));
    localparam logic [ADDR_BITS-1:0] SUB_MASK = ADDR_BITS'((1 << SUB) - 1);

    wire [ADDR_BITS-1:0] addr_word;
    wire [ADDR_BITS-1:0] sub_sel;
    wire [OFF_BITS-1:0] doff;
    wire [POFF_BITS-1:0] poff;

    // Narrow words pack upward from bit 0 of a storage word, so a wide reader
    // sees consecutive narrow words side by side.
    assign addr_word = addr >> SUB;
    assign idx = addr_word[IDX_BITS-1:0];
    assign sub_sel = addr & SUB_MASK;
    assign doff = OFF_BITS'(sub_sel << LGD);
    // Parity slot follows the byte slot, so parity stays with its byte.
    assign poff = POFF_BITS'(sub_sel << LGP);

    assign wdata_cut = wdata & LOW_D;
    assign wpar_cut = wpar & LOW_P;
    assign dmask = LOW_D << doff;
    assign dpos = wdata_cut << doff;
    assign pmask = LOW_P << poff;
    assign ppos = wpar_cut << poff;
    assign rdata = (word_rd >> doff) & LOW_D;
    assign rpar = (par_rd >> poff) & LOW_P;

endmodule : bram_lane_map

// ==== verification/bram_aspect_monitor.sv ====
// Purpose: Concurrent checks on the ports of the aspect-ratio block memory.
// Assumes: Port A is 36 bits wide, port B 9 bits, new-data mode, no inversion.
// Notes: A port clock edge takes effect three system clocks after it is captured.
`timescale 1ns/10ps
module bram_aspect_monitor import bram_aspect_pkg::*; #(
    parameter logic [WORD_BITS-1:0] SET_DATA_A = 32'h00000000
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic port_clk_a,
    input wire logic port_enable_a,
    input wire logic write_enable_a,
    input wire logic output_set_reset_a,
    input wire logic [WORD_BITS-1:0] write_data_bus_a,
    input wire logic [PAR_BITS-1:0] parity_write_bus_a,
    input wire logic port_clk_b,
    input wire logic port_enable_b,
    input wire logic [WORD_BITS-1:0] write_data_bus_b,
    input wire logic [WORD_BITS-1:0] read_data_bus_a,
    input wire logic [PAR_BITS-1:0] parity_read_bus_a,
    input wire logic [MULT_BITS-1:0] mult_operand_a,
    input wire logic [WORD_BITS-1:0] read_data_bus_b,
    input wire logic [PAR_BITS-1:0] parity_read_bus_b,
    input wire logic [MULT_BITS-1:0] mult_operand_b
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    chk_mult_follow_a: assert property (
        !$past(rst) |-> mult_operand_a == $past(write_data_bus_a[31:16]))
        else $error("operand A does not follow write data");
    chk_mult_follow_b: assert property (
        !$past(rst) |-> mult_operand_b == $past(write_data_bus_b[31:16]))
        else $error("operand B does not follow write data");
    chk_idle_hold_a: assert property (
        !port_enable_a [*2] |=> $stable(read_data_bus_a) && $stable(parity_read_bus_a))
        else $error("port A output moved while disabled");
    chk_idle_hold_b: assert property (
        !port_enable_b [*2] |=> $stable(read_data_bus_b) && $stable(parity_read_bus_b))
        else $error("port B output moved while disabled");
    chk_lane_zero_b: assert property (
        read_data_bus_b[31:8] == 24'h000000 && parity_read_bus_b[3:1] == 3'h0)
        else $error("port B absent lanes not zero");
    chk_pin_quiet_a: assert property (
        $stable(port_clk_a) [*4] |=> $stable(read_data_bus_a))
        else $error("port A output moved without a port clock edge");
    chk_edge_latency_b: assert property (
        $rose(port_clk_b) |=> $stable(read_data_bus_b) [*2])
        else $error("port B answered too early");
    chk_new_data_a: assert property (
        $rose(port_clk_a) && port_enable_a && write_enable_a && !output_set_reset_a
        |-> ##3 read_data_bus_a == $past(write_data_bus_a, 3)
        && parity_read_bus_a == $past(parity_write_bus_a, 3))
        else $error("port A write did not show new data");
    chk_set_reset_a: assert property (
        $rose(port_clk_a) && port_enable_a && output_set_reset_a
        |-> ##3 read_data_bus_a == SET_DATA_A)
        else $error("port A set/reset value wrong");
endmodule : bram_aspect_monitor
bind bram_aspect_core bram_aspect_monitor #(.SET_DATA_A(SET_DATA_A)) bram_aspect_monitor_i (
    .clock(clock), .rst(rst), .port_clk_a(port_clk_a), .port_enable_a(port_enable_a),
    .write_enable_a(write_enable_a), .output_set_reset_a(output_set_reset_a),
    .write_data_bus_a(write_data_bus_a), .parity_write_bus_a(parity_write_bus_a),
    .port_clk_b(port_clk_b), .port_enable_b(port_enable_b),
    .write_data_bus_b(write_data_bus_b), .read_data_bus_a(read_data_bus_a),
    .parity_read_bus_a(parity_read_bus_a), .mult_operand_a(mult_operand_a),
    .read_data_bus_b(read_data_bus_b), .parity_read_bus_b(parity_read_bus_b),
    .mult_operand_b(mult_operand_b));

// ==== verification/port_user_model.sv ====
// Purpose: User logic that drives one memory port with a single port clock pulse.
// Assumes: go is a one-cycle request; the pulse is 5 clocks high, then 5 low.
// Notes: Released address and data lines show the inverse of their last value and controls drop to 0, so stale data never passes.
`timescale 1ns/10ps
module port_user_model import bram_aspect_pkg::*; (
    input wire logic clock,
    input wire logic rst,
    input wire logic go,
    input wire logic en_in,
    input wire logic we_in,
    input wire logic ssr_in,
    input wire logic [ADDR_BITS-1:0] addr_in,
    input wire logic [WORD_BITS-1:0] data_in,
    input wire logic [PAR_BITS-1:0] par_in,
    output logic port_clk = 1'b0,
    output logic en = 1'b0,
    output logic we = 1'b0,
    output logic output_set_reset = 1'b0,
    output logic [ADDR_BITS-1:0] addr = 14'h0000,
    output logic [WORD_BITS-1:0] wdata = 32'h00000000,
    output logic [PAR_BITS-1:0] wpar = 4'h0,
    output logic busy = 1'b0
);
    logic [3:0] cnt_q = 4'h0;
    // Controls stay put for the whole pulse, longer than the port needs to see them.
    always @(posedge clock) begin
        if (rst) begin
            {port_clk, en, we, output_set_reset, busy} <= 5'h00;
            cnt_q <= 4'h0;
        end else if (go && !busy) begin
            {port_clk, busy} <= 2'h3;
            {en, we, output_set_reset} <= {en_in, we_in, ssr_in};
            {addr, wdata, wpar} <= {addr_in, data_in, par_in};
            cnt_q <= 4'h0;
        end else if (busy) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h4) begin
                port_clk <= 1'b0;
            end
            if (cnt_q == 4'h9) begin
                {en, we, output_set_reset, busy} <= 4'h0;
                {addr, wdata, wpar} <= ~{addr, wdata, wpar};
            end
        end
    end
endmodule : port_user_model

// ==== verification/tb.sv ====
// Purpose: Self-checking bench for the aspect-ratio block memory, A x36 and B x9.
// Assumes: Default parameters; one port operation at a time.
// Notes: Outputs are judged once the driving pulse has finished.
`timescale 1ns/10ps
module tb import bram_aspect_pkg::*;;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [1:0] go = 2'h0;
    logic en_in = 1'b0, we_in = 1'b0, ssr_in = 1'b0;
    logic [ADDR_BITS-1:0] addr_in = 14'h0000;
    logic [WORD_BITS-1:0] data_in = 32'h00000000;
    logic [PAR_BITS-1:0] par_in = 4'h0;
    logic [1:0] pclk, pen, pwe, pssr, busy;
    logic [ADDR_BITS-1:0] paddr [2];
    logic [WORD_BITS-1:0] pdata [2];
    logic [PAR_BITS-1:0] ppar [2];
    logic [WORD_BITS-1:0] rd_a, rd_b;
    logic [PAR_BITS-1:0] rp_a, rp_b;
    logic [MULT_BITS-1:0] mo_a, mo_b;
    int num_errors = 0;
    int tests_run = 0;
    always #12.5 clock = ~clock;
    for (genvar g = 0; g < 2; g++) begin : user
        port_user_model u (.clock(clock), .rst(rst), .go(go[g]), .en_in(en_in),
            .we_in(we_in), .ssr_in(ssr_in), .addr_in(addr_in), .data_in(data_in),
            .par_in(par_in), .port_clk(pclk[g]), .en(pen[g]), .we(pwe[g]), .output_set_reset(pssr[g]),
            .addr(paddr[g]), .wdata(pdata[g]), .wpar(ppar[g]), .busy(busy[g]));
    end
    bram_aspect_core bram_aspect_core_i (.clock(clock), .rst(rst),
        .port_clk_a(pclk[0]), .port_enable_a(pen[0]), .write_enable_a(pwe[0]),
        .output_set_reset_a(pssr[0]), .address_a(paddr[0]), .write_data_bus_a(pdata[0]),
        .parity_write_bus_a(ppar[0]), .port_clk_b(pclk[1]), .port_enable_b(pen[1]),
        .write_enable_b(pwe[1]), .output_set_reset_b(pssr[1]), .address_b(paddr[1]),
        .write_data_bus_b(pdata[1]), .parity_write_bus_b(ppar[1]),
        .read_data_bus_a(rd_a), .parity_read_bus_a(rp_a), .mult_operand_a(mo_a),
        .read_data_bus_b(rd_b), .parity_read_bus_b(rp_b), .mult_operand_b(mo_b));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    // Only one port moves at a time, so no cell is ever written from both at once.
    task automatic run(input int b, input logic en, we, output_set_reset, input logic [13:0] ad,
                       input logic [31:0] d, input logic [3:0] p);
        @(posedge clock);
        go[b] <= 1'b1;
        {en_in, we_in, ssr_in, addr_in, data_in, par_in} <= {en, we, output_set_reset, ad, d, p};
        @(posedge clock);
        go[b] <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 20 && busy[b] !== 1'b0; i++) @(posedge clock);
        // A pulse that never finishes is counted, so a stuck model cannot pass.
        if (busy[b] !== 1'b0) begin
            num_errors++;
            $display("FAIL t=%0t busy=%h expected=%h", $time, busy[b], 1'b0);
        end
        #1;
    endtask : run
    task automatic wide_to_narrow;
        run(0, 1, 1, 0, 14'h0005, 32'h44332211, 4'hA);
        check(rd_a, 32'h44332211);
        check(rp_a, 4'hA);
        for (int i = 0; i < 4; i++) begin
            run(1, 1, 0, 0, 14'(14'h3814 + i), 32'h0, 4'h0);
            check(rd_b, 32'(8'h11 * (i + 1)));
            check(rp_b, 4'(i % 2));
        end
    endtask : wide_to_narrow
    task automatic narrow_to_wide;
        for (int i = 0; i < 4; i++) begin
            run(1, 1, 1, 0, 14'(40 + i), 32'hFFFFFFA0 + i, 4'hE | 4'((i + 1) % 2));
            check(rd_b, 32'hA0 + i);
        end
        run(0, 1, 0, 0, 14'h3E0A, 32'h0, 4'h0);
        check(rd_a, 32'hA3A2A1A0);
        check(rp_a, 4'h5);
    endtask : narrow_to_wide
    task automatic enable_gate;
        run(0, 0, 1, 0, 14'h0005, 32'hDEADBEEF, 4'hF);
        check(rd_a, 32'hA3A2A1A0);
        run(0, 1, 0, 0, 14'h0005, 32'h0, 4'h0);
        check(rd_a, 32'h44332211);
        run(0, 0, 0, 0, 14'h000A, 32'h0, 4'h0);
        check(rd_a, 32'h44332211);
    endtask : enable_gate
    task automatic set_reset_and_mult;
        logic [31:0] va, vb;
        run(0, 1, 0, 1, 14'h0005, 32'h12345678, 4'h0);
        check(rd_a, 32'h00000000);
        run(1, 1, 1, 0, 14'h0100, 32'hCAFE0077, 4'h1);
        va = pdata[0];
        vb = pdata[1];
        @(posedge clock);
        #1;
        check(mo_a, va[31:16]);
        check(mo_b, vb[31:16]);
    endtask : set_reset_and_mult
    task automatic mid_reset;
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        run(0, 1, 0, 0, 14'h0005, 32'h0, 4'h0);
        check(rd_a, 32'h44332211);
    endtask : mid_reset
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        wide_to_narrow();
        narrow_to_wide();
        enable_gate();
        set_reset_and_mult();
        mid_reset();
        summarize();
    end
    initial begin
        #(4000 * 25);
        num_errors++;
        summarize();
    end
endmodule : tb
